// [phase_tap_accum.sv]
`default_nettype none
module phase_tap_accum
  import pll_adj_pkg::*;
#(
  parameter int PW = 16
)(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          step,
  input  wire logic          later,
  output logic [PW-1:0]      phase
);
  typedef struct packed {
    logic [PW-1:0] phase;
  } tap_state_t;

  tap_state_t s_reg;
  tap_state_t s_next;

  // Low three bits are the tap (one eighth VCO period); upper bits count turns
  always_comb
  begin
    s_next = s_reg;
    if (step)
    begin
      if (later)
        s_next.phase = s_reg.phase + PW'(1);
      else
        s_next.phase = s_reg.phase - PW'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign phase = s_reg.phase;
endmodule : phase_tap_accum
`default_nettype wire

// [pll_adj_pkg.sv]
`default_nettype none
package pll_adj_pkg;
  // APB byte addresses
  localparam logic [7:0] BW_CTRL_ADDR     = 8'h00;
  localparam logic [7:0] STATUS_ADDR      = 8'h04;
  localparam logic [7:0] INFO_ADDR        = 8'h08;
  localparam logic [7:0] CNT_CFG_BASE     = 8'h40;
  localparam logic [7:0] CNT_FACTOR_BASE  = 8'h80;
  localparam logic [7:0] PHASE_BASE       = 8'hC0;
  localparam logic [1:0] ADDR_AREA_CFG    = 2'h1;
  localparam logic [1:0] ADDR_AREA_FACTOR = 2'h2;
  localparam logic [1:0] ADDR_AREA_PHASE  = 2'h3;

  // Bandwidth control fields
  localparam int BW_PUMP_LSB = 0;
  localparam int BW_RES_LSB  = 3;
  localparam int BW_CAP_LSB  = 8;
  localparam int BW_KDIV_BIT = 10;

  // Counter setting word: high count, low count, bypass, odd-divide correction
  localparam int CFG_W          = 18;
  localparam int CFG_HIGH_LSB   = 0;
  localparam int CFG_LOW_LSB    = 8;
  localparam int CFG_BYPASS_BIT = 16;
  localparam int CFG_ODD_BIT    = 17;

  // Status fields
  localparam int ST_COMPLETE_BIT = 0;
  localparam int ST_BUSY_BIT     = 1;
  localparam int ST_LEGAL_BIT    = 2;
  localparam int ST_SEL_LSB      = 3;
  localparam int ST_DIR_BIT      = 7;
  localparam int ST_COUNT_LSB    = 16;

  // Counter indices
  localparam int NUM_CNT    = 12;
  localparam int CFG_IDX_M  = 0;
  localparam int CFG_IDX_N  = 1;
  localparam int CFG_IDX_C0 = 2;
  localparam int NUM_TAP    = 11;

  // Target select codes
  localparam logic [3:0] SEL_ALL_POST = 4'h0;
  localparam logic [3:0] SEL_FEEDBACK = 4'h1;
  localparam logic [3:0] SEL_POST0    = 4'h2;

  // Reset values
  localparam logic [2:0]       PUMP_RST = 3'h1;
  localparam logic [4:0]       RES_RST  = 5'h10;
  localparam logic [1:0]       CAP_RST  = 2'h1;
  localparam logic             KDIV_RST = 1'b1;
  localparam logic [CFG_W-1:0] CFG_RST  = 18'h10000;

  // Internal shift settling time
  localparam int CLK_PERIOD_NS = 40;
  localparam int SHIFT_TIME_NS = 80;
  localparam logic [3:0] SHIFT_CYCLES =
    4'((SHIFT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
endpackage : pll_adj_pkg
`default_nettype wire

// [pll_bandwidth_bypass_phase_shift.sv]
// Summary of operation
// - Pump and filter codes are writable at any time without disturbing other state.
// - Bypassed counter acts as factor one.
// - Bypass bit set ignores other counter bits; clear means normal divide.
// - Post-scale divider bit at 0 bypasses it, opposite polarity.
// - Each step moves selected counters by one tap, an eighth VCO period.
// - Output clocks keep toggling during a phase adjustment.
// - Outputs 7 to 9 exist only on the ten-counter variant.
// - Direction 1 shifts later, 0 shifts earlier.
// - Select and direction are registered on a rising clock edge.
// - Request sampled once per clock; held at least two cycles by controller.
// - Next rising edge after sampling captures select, direction and starts shifting.
// - Completion drops on that edge and rises after internal shift time.
// - One request pulse gives exactly one tap shift.
// - Any number of successive steps is accepted.
// - Counter setting holds 8-bit high, 8-bit low, bypass and odd bits.
`default_nettype none
module pll_bandwidth_bypass_phase_shift
  import pll_adj_pkg::*;
#(
  parameter int NUM_POST = 10,
  parameter int PHASE_W  = 16
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  shift_target_select,
  input  wire logic        shift_direction,
  input  wire logic        shift_request,
  output logic             shift_complete,
  output logic [2:0]       pump_current_code,
  output logic [4:0]       filter_resistor_code,
  output logic [1:0]       filter_capacitor_code,
  output logic             post_scale_div_on
);
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SHIFT,
    ST_RELEASE
  } shift_state_t;

  typedef struct packed {
    shift_state_t                      st;
    logic                              req_q;
    logic [3:0]                        sel;
    logic                              dir;
    logic [3:0]                        cnt;
    logic                              complete;
    logic [NUM_TAP-1:0]                step_mask;
    logic [15:0]                       shifts;
    logic [2:0]                        pump;
    logic [4:0]                        res;
    logic [1:0]                        cap;
    logic                              kdiv;
    logic [NUM_CNT-1:0][CFG_W-1:0]     cfg;
    logic                              pready;
    logic [31:0]                       prdata;
    logic                              pslverr;
  } regs_t;

  regs_t                           r_reg;
  regs_t                           r_next;
  logic [NUM_TAP-1:0][PHASE_W-1:0] phase;
  logic [NUM_TAP-1:0]              sel_mask;
  logic                            codes_legal;
  logic                            setup_rd;
  logic                            access_wr;
  logic [3:0]                      word_idx;
  logic [1:0]                      area;
  logic [31:0]                     rd_word;
  logic                            rd_err;
  logic [15:0]                     cnt_present;
  logic                            idx_present;
  logic                            phase_present;
  logic                            word_aligned;

  // One accumulator per shiftable counter; index 0 is feedback, 1 onward outputs
  genvar gi;
  generate
    for (gi = 0; gi < NUM_TAP; gi++)
    begin : g_tap
      if (gi <= NUM_POST)
      begin : g_fit
        phase_tap_accum #(
          .PW (PHASE_W)
        ) u_tap (
          .pclk    (pclk),
          .presetn (presetn),
          .step    (r_reg.step_mask[gi]),
          .later   (r_reg.dir),
          .phase   (phase[gi])
        );
      end
      else
      begin : g_absent
        // Not fitted on the smaller variant; reads as zero and never steps
        assign phase[gi] = '0;
      end
    end
  endgenerate

  // Decode of the latched target select
  always_comb
  begin
    sel_mask = '0;
    if (r_reg.sel == SEL_ALL_POST)
    begin
      for (int i = 0; i < NUM_POST; i++)
        sel_mask[i + 1] = 1'b1;
    end
    else if (r_reg.sel == SEL_FEEDBACK)
      sel_mask[0] = 1'b1;
    else
    begin
      for (int i = 0; i < NUM_POST; i++)
        if (r_reg.sel == 4'(SEL_POST0 + 4'(i)))
          sel_mask[i + 1] = 1'b1;
    end
  end

  // Counters beyond the fitted post-scale count have no setting registers
  always_comb
  begin
    cnt_present            = '0;
    cnt_present[CFG_IDX_M] = 1'b1;
    cnt_present[CFG_IDX_N] = 1'b1;
    for (int i = 0; i < NUM_POST; i++)
      cnt_present[CFG_IDX_C0 + i] = 1'b1;
  end

  // Flags codes that the controller must not program
  always_comb
  begin
    logic pump_ok;
    logic res_ok;
    logic cap_ok;
    pump_ok = 1'b0;
    res_ok  = 1'b0;
    cap_ok  = 1'b0;
    case (r_reg.pump)
      3'h0, 3'h1, 3'h3, 3'h7: pump_ok = 1'b1;
      default:                pump_ok = 1'b0;
    endcase
    case (r_reg.res)
      5'h00, 5'h03, 5'h04, 5'h08, 5'h10, 5'h13,
      5'h14, 5'h18, 5'h1B, 5'h1C, 5'h1E: res_ok = 1'b1;
      default:                            res_ok = 1'b0;
    endcase
    case (r_reg.cap)
      2'h0, 2'h1, 2'h3: cap_ok = 1'b1;
      default:          cap_ok = 1'b0;
    endcase
    codes_legal = pump_ok & res_ok & cap_ok;
  end

  // Effective factor of one counter setting
  function automatic logic [8:0] factor_of(input logic [CFG_W-1:0] c);
    logic [8:0] f;
    if (c[CFG_BYPASS_BIT])
      f = 9'h001;
    else
      f = {1'b0, c[CFG_HIGH_LSB +: 8]} + {1'b0, c[CFG_LOW_LSB +: 8]};
    return f;
  endfunction : factor_of

  // Read data is taken at setup, so the one wait state hides the decode
  assign setup_rd  = psel & ~penable & ~pwrite;
  // Writes land only at the ready edge, never in the first access cycle
  assign access_wr = psel & penable & pwrite & r_reg.pready;
  assign area      = paddr[7:6];
  assign word_idx  = paddr[5:2];
  assign word_aligned  = (paddr[1:0] == 2'h0);
  assign idx_present   = cnt_present[word_idx];
  assign phase_present = (word_idx != 4'h0) && (int'(word_idx) <= NUM_POST + 1);

  // Read data and error for the current address
  always_comb
  begin
    rd_word = '0;
    rd_err  = 1'b0;
    case (area)
      2'h0:
      begin
        if (paddr == BW_CTRL_ADDR)
        begin
          rd_word[BW_PUMP_LSB +: 3] = r_reg.pump;
          rd_word[BW_RES_LSB +: 5]  = r_reg.res;
          rd_word[BW_CAP_LSB +: 2]  = r_reg.cap;
          rd_word[BW_KDIV_BIT]      = r_reg.kdiv;
        end
        else if (paddr == STATUS_ADDR)
        begin
          rd_word[ST_COMPLETE_BIT]   = r_reg.complete;
          rd_word[ST_BUSY_BIT]       = (r_reg.st == ST_SHIFT);
          rd_word[ST_LEGAL_BIT]      = codes_legal;
          rd_word[ST_SEL_LSB +: 4]   = r_reg.sel;
          rd_word[ST_DIR_BIT]        = r_reg.dir;
          rd_word[ST_COUNT_LSB +: 16] = r_reg.shifts;
        end
        else if (paddr == INFO_ADDR)
          rd_word[7:0] = 8'(NUM_POST);
        else
          rd_err = 1'b1;
      end
      ADDR_AREA_CFG:
      begin
        if (word_aligned && idx_present)
          rd_word[CFG_W-1:0] = r_reg.cfg[word_idx];
        else
          rd_err = 1'b1;
      end
      ADDR_AREA_FACTOR:
      begin
        if (word_aligned && idx_present)
          rd_word[8:0] = factor_of(r_reg.cfg[word_idx]);
        else if (paddr[1:0] == 2'h0 && int'(word_idx) == NUM_CNT)
          rd_word[8:0] = r_reg.kdiv ? 9'h002 : 9'h001;
        else
          rd_err = 1'b1;
      end
      ADDR_AREA_PHASE:
      begin
        if (word_aligned && phase_present)
          rd_word[PHASE_W-1:0] = phase[word_idx - 4'h1];
        else
          rd_err = 1'b1;
      end
      default:
        rd_err = 1'b1;
    endcase
  end

  always_comb
  begin
    r_next = r_reg;

    // APB slave, one wait state
    r_next.pready  = psel & penable & ~r_reg.pready;
    r_next.pslverr = psel & penable & ~r_reg.pready & rd_err;
    if (setup_rd)
      r_next.prdata = rd_word;
    if (access_wr && !rd_err)
    begin
      if (paddr == BW_CTRL_ADDR)
      begin
        // Bandwidth retunes live; the shift engine and counters are untouched
        r_next.pump = pwdata[BW_PUMP_LSB +: 3];
        r_next.res  = pwdata[BW_RES_LSB +: 5];
        r_next.cap  = pwdata[BW_CAP_LSB +: 2];
        r_next.kdiv = pwdata[BW_KDIV_BIT];
      end
      else if (area == ADDR_AREA_CFG)
        r_next.cfg[word_idx] = pwdata[CFG_W-1:0];
    end

    // Phase-step handshake
    // One rising-edge sample here stands in for the falling-edge latch
    r_next.req_q     = shift_request;
    r_next.step_mask = '0;
    case (r_reg.st)
      ST_IDLE:
      begin
        r_next.complete = 1'b1;
        // Absent select codes still run the handshake, they just move no tap
        if (r_reg.req_q)
        begin
          r_next.sel      = shift_target_select;
          r_next.dir      = shift_direction;
          r_next.complete = 1'b0;
          r_next.cnt      = SHIFT_CYCLES - 4'h1;
          r_next.st       = ST_SHIFT;
        end
      end
      ST_SHIFT:
      begin
        if (r_reg.cnt == 4'h0)
        begin
          // Counters keep running; only their tap selection moves
          r_next.step_mask = sel_mask;
          r_next.complete  = 1'b1;
          r_next.shifts    = r_reg.shifts + 16'h1;
          r_next.st        = ST_RELEASE;
        end
        else
          r_next.cnt = r_reg.cnt - 4'h1;
      end
      ST_RELEASE:
      begin
        // A long pulse must not re-arm; wait for the request to drop
        if (!r_reg.req_q)
          r_next.st = ST_IDLE;
      end
      default:
        r_next.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r_reg           <= '0;
      r_reg.st        <= ST_IDLE;
      r_reg.complete  <= 1'b1;
      r_reg.pump      <= PUMP_RST;
      r_reg.res       <= RES_RST;
      r_reg.cap       <= CAP_RST;
      r_reg.kdiv      <= KDIV_RST;
      // Counters come up bypassed, so every output runs before software sets it
      r_reg.cfg       <= {NUM_CNT{CFG_RST}};
    end
    else
      r_reg <= r_next;
  end

  assign prdata                = r_reg.prdata;
  assign pready                = r_reg.pready;
  assign pslverr               = r_reg.pslverr;
  assign shift_complete        = r_reg.complete;
  assign pump_current_code     = r_reg.pump;
  assign filter_resistor_code  = r_reg.res;
  assign filter_capacitor_code = r_reg.cap;
  assign post_scale_div_on     = r_reg.kdiv;
endmodule : pll_bandwidth_bypass_phase_shift
`default_nettype wire

// [pll_shift_asserts.sv]
`default_nettype none
module pll_shift_checker
  import pll_adj_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        shift_request,
  input wire logic        shift_complete,
  input wire logic [2:0]  pump_current_code,
  input wire logic [4:0]  filter_resistor_code,
  input wire logic [1:0]  filter_capacitor_code,
  input wire logic        post_scale_div_on
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic        bw_wr;
  logic [10:0] bw;
  assign bw_wr = psel && penable && pready && pwrite && (paddr == BW_CTRL_ADDR);
  assign bw = {post_scale_div_on, filter_capacitor_code, filter_resistor_code, pump_current_code};
  property p_start;
    $rose(shift_request) && shift_complete |-> ##2 !shift_complete;
  endproperty
  a_start: assert property (p_start) else $error("complete kept high");
  property p_low_len;
    $fell(shift_complete) |=> !shift_complete ##1 shift_complete;
  endproperty
  a_low_len: assert property (p_low_len) else $error("complete low time wrong");
  property p_one_pulse;
    $rose(shift_complete) && shift_request |=> shift_complete;
  endproperty
  a_one_pulse: assert property (p_one_pulse) else $error("held request restarted");
  property p_idle;
    !shift_request [*4] |-> shift_complete;
  endproperty
  a_idle: assert property (p_idle) else $error("complete low while idle");
  property p_reset_high;
    $rose(presetn) |-> shift_complete;
  endproperty
  a_reset_high: assert property (p_reset_high) else $error("complete low after reset");
  property p_bw_wr;
    bw_wr |=> {21'h0, bw} == ($past(pwdata) & 32'h7FF);
  endproperty
  a_bw_wr: assert property (p_bw_wr) else $error("bandwidth write lost");
  property p_bw_keep;
    !bw_wr |=> $stable(bw);
  endproperty
  a_bw_keep: assert property (p_bw_keep) else $error("bandwidth changed unasked");
  property p_wait_state;
    psel && penable && !pready |=> pready ##1 !pready;
  endproperty
  a_wait_state: assert property (p_wait_state) else $error("ready timing wrong");
  c_step: cover property (shift_request && !shift_complete);
  c_bw: cover property (bw_wr);
  c_hold: cover property (shift_request && shift_complete && $past(shift_request, 4));
endmodule : pll_shift_checker
bind pll_bandwidth_bypass_phase_shift pll_shift_checker u_chk (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pready, .shift_request, .shift_complete,
  .pump_current_code, .filter_resistor_code, .filter_capacitor_code, .post_scale_div_on);
`default_nettype wire

// [shift_ctrl_model.sv]
`default_nettype none
module shift_ctrl_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       go,
  input  wire logic [3:0] sel_in,
  input  wire logic       dir_in,
  input  wire logic [3:0] hold,
  input  wire logic       shift_complete,
  output logic [3:0]      shift_target_select,
  output logic            shift_direction,
  output logic            shift_request,
  output logic            busy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] st;
  logic [4:0] n;
  logic       seen;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {st, n, seen, shift_request, busy, shift_direction} <= '0;
      shift_target_select <= '0;
    end
    else
    case (st)
      2'd0: if (go)
      begin
        shift_target_select <= sel_in;
        shift_direction     <= dir_in;
        busy                <= 1'b1;
        st                  <= 2'd1;
      end
      2'd1:
      begin
        shift_request <= 1'b1;
        {n, seen}     <= '0;
        st            <= 2'd2;
      end
      2'd2:
      begin
        n    <= n + 5'd1;
        seen <= seen | !shift_complete;
        if ((seen || !shift_complete) && n >= 5'(hold) + 5'd1)
        begin
          shift_request <= 1'b0;
          st            <= 2'd3;
        end
      end
      default: if (shift_complete)
      begin
        // Released levels turn over so a stale value never passes for a live one
        shift_target_select <= ~shift_target_select;
        shift_direction     <= ~shift_direction;
        busy                <= 1'b0;
        st                  <= 2'd0;
      end
    endcase
  end
endmodule : shift_ctrl_model
`default_nettype wire

// [testbench.sv]
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fail_count++; \
  $display("[ERR] %0t got %0h want %0h", $time, (a), (e)); end end
module testbench
  import pll_adj_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, dir, req, complete, div_on, busy, err;
  logic [3:0]  sel, m_sel = 4'h0, m_hold = 4'h0;
  logic        go = 1'b0, m_dir = 1'b0;
  logic [2:0]  pump;
  logic [4:0]  res;
  logic [1:0]  cap;
  int          fail_count = 0;
  int          checks_done = 0;
  always #20 pclk = ~pclk;
  pll_bandwidth_bypass_phase_shift dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .shift_target_select(sel), .shift_direction(dir),
    .shift_request(req), .shift_complete(complete), .pump_current_code(pump),
    .filter_resistor_code(res), .filter_capacitor_code(cap), .post_scale_div_on(div_on));
  shift_ctrl_model core (.pclk, .presetn, .go, .sel_in(m_sel), .dir_in(m_dir), .hold(m_hold),
    .shift_complete(complete), .shift_target_select(sel), .shift_direction(dir),
    .shift_request(req), .busy);
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
    if (pready !== 1'b1)
      fail_count++;
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge keeps a following setup from landing in the same time step
    @(posedge pclk);
  endtask : apb
  task automatic step(input logic [3:0] s, input logic d, input logic [3:0] h);
    int n;
    m_sel <= s;
    m_dir <= d;
    m_hold <= h;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    n = 0;
    do @(posedge pclk); while ((busy !== 1'b0 || n < 2) && ++n < 100);
    `CHK(n < 100, 1'b1)
  endtask : step
  task automatic t_step(input logic [3:0] s, input logic d, input logic [3:0] h,
                        input logic [7:0] j, input logic [15:0] dl);
    logic [31:0] a, b;
    apb(1'b0, PHASE_BASE + (j << 2), 32'h0, a);
    step(s, d, h);
    apb(1'b0, PHASE_BASE + (j << 2), 32'h0, b);
    `CHK(b[15:0], a[15:0] + dl)
    apb(1'b0, STATUS_ADDR, 32'h0, b);
    `CHK(b[7:0], {d, s, 3'b001})
  endtask : t_step
  task automatic t_regs;
    logic [31:0] r;
    apb(1'b0, BW_CTRL_ADDR, 32'h0, r);
    `CHK(r, 32'h581)
    apb(1'b0, CNT_CFG_BASE, 32'h0, r);
    `CHK(r, 32'(CFG_RST))
    apb(1'b0, CNT_FACTOR_BASE, 32'h0, r);
    `CHK(r, 32'h1)
    apb(1'b1, BW_CTRL_ADDR, 32'h3F7, r);
    `CHK({div_on, cap, res, pump}, 11'h3F7)
    apb(1'b0, CNT_FACTOR_BASE + 8'h30, 32'h0, r);
    `CHK(r, 32'h1)
    apb(1'b0, STATUS_ADDR, 32'h0, r);
    `CHK(r[2], 1'b1)
    apb(1'b1, BW_CTRL_ADDR, 32'h402, r);
    apb(1'b0, STATUS_ADDR, 32'h0, r);
    `CHK(r[2], 1'b0)
    apb(1'b0, CNT_FACTOR_BASE + 8'h30, 32'h0, r);
    `CHK(r, 32'h2)
    apb(1'b1, CNT_CFG_BASE + 8'h08, 32'h00605, r);
    apb(1'b0, CNT_FACTOR_BASE + 8'h08, 32'h0, r);
    `CHK(r, 32'd11)
    apb(1'b1, CNT_CFG_BASE + 8'h08, 32'h10605, r);
    apb(1'b0, CNT_FACTOR_BASE + 8'h08, 32'h0, r);
    `CHK(r, 32'h1)
    apb(1'b0, 8'h30, 32'h0, r);
    `CHK({err, r}, 33'h100000000)
    apb(1'b0, INFO_ADDR, 32'h0, r);
    `CHK(r, 32'd10)
  endtask : t_regs
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    repeat (20) @(posedge pclk);
    `CHK({div_on, cap, res, pump, complete}, {1'b1, 2'h1, 5'h10, 3'h1, 1'b1})
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_step(SEL_POST0, 1'b1, 4'h0, 8'h2, 16'h0001);
    t_step(SEL_POST0, 1'b0, 4'h0, 8'h2, 16'hFFFF);
    t_step(SEL_FEEDBACK, 1'b1, 4'h6, 8'h1, 16'h0001);
    t_step(SEL_ALL_POST, 1'b1, 4'h0, 8'hB, 16'h0001);
    t_step(4'hB, 1'b0, 4'h2, 8'hB, 16'hFFFF);
    t_step(4'hC, 1'b1, 4'h0, 8'h2, 16'h0000);
    tally_and_finish();
  end
  initial
  begin
    #2000000;
    fail_count++;
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
